// File: hw/cpu_bus_trace_debugger_defs.vh
// Register map, field positions and constants of the bus trace debugger
`ifndef CPU_BUS_TRACE_DEBUGGER_DEFS_VH
`define CPU_BUS_TRACE_DEBUGGER_DEFS_VH
`define OFS_CONTROL_ONE   8'h20
`define OFS_STATE_FLAGS   8'h21
`define OFS_TRACE_CONTROL 8'h22
`define OFS_CONTROL_TWO   8'h23
`define OFS_TRACE_HIGH    8'h24
`define OFS_TRACE_LOW     8'h25
`define OFS_ENTRY_COUNT   8'h26
`define OFS_SEQ_CONTROL   8'h27
`define OFS_CMP_CONTROL   8'h28
`define OFS_ADDR_UPPER    8'h29
`define OFS_ADDR_MIDDLE   8'h2A
`define OFS_ADDR_LOWER    8'h2B
`define OFS_DATA_HIGH     8'h2C
`define OFS_DATA_LOW      8'h2D
`define OFS_MASK_HIGH     8'h2E
`define OFS_MASK_LOW      8'h2F
`define C1_ARM            7
`define C1_IMMEDIATE_TRIGGER_REQUEST           6
`define C1_BDM            4
`define C1_BRK_EN         3
`define TC_TRACE_SOURCE_ENABLE        6
`define TC_TRIGGER_ALIGNMENT_SELECT         0
`define CC_SZE            7
`define CC_SZ             6
`define CC_TAG            5
`define CC_BRK            4
`define CC_RW             3
`define CC_RWE            2
`define CC_NDB            1
`define CC_COMPARATOR_ON          0
`define CTL_MASK_A        8'hFF
`define CTL_MASK_B        8'hFD
`define CTL_MASK_C        8'h3D
`define BANK_NONE         2'h3
`define ST_IDLE           3'h0
`define ST_FIRST          3'h1
`define ST_SECOND         3'h2
`define ST_THIRD          3'h3
`define ST_FINAL          3'h4
`define TM_NORMAL         2'h0
`define TM_LOOP           2'h1
`define TM_DETAIL         2'h2
`define TM_PURE_PC        2'h3
`define PAIR_SIMPLE       2'h0
`define PAIR_INSIDE       2'h1
`define PAIR_OUTSIDE      2'h2
`define TRACE_DEPTH       5'h10
`define LINE_ADDR         2'h0
`define LINE_DATA         2'h1
`define RST_BYTE          8'h00
`endif

// File: hw/cpu_bus_trace_debugger.v
// Bus comparators, state sequencer and trace buffer of the debug block
//
// Overview of operation
// - Comparator matches on monitored CPU bus advance the state sequencer.
// - Entering Final starts tracing and/or raises a breakpoint per configuration.
// - Writing one to the trigger bit forces Final without any match.
// - Trace buffer is read through a two-byte window by 16-bit word reads.
// - When secured no tracing and no trace start; breakpoints and tags still work.
// - First comparator matches full address and masked 16-bit data.
// - Second and third comparators match full address only.
// - Optional read/write qualifier; first and second comparators also byte/word size.
// - Simple, inside-range and outside-range comparison modes.
// - Tagged match marks fetched opcode and hits when it executes.
// - Forced match takes effect at next instruction boundary.
// - Breakpoint goes to background debug or software interrupt by configuration.
// - Normal trace stores program counter only on program-flow changes.
// - Loop trace as normal but drops repeat of previous source address.
// - Detail trace stores address and data of non-free, non-fetch cycles.
// - Pure program-counter trace stores every executed address.
// - Four-stage sequencer; Final is the trigger; begin or end alignment.
// - No monitoring during debug-host accesses or active background debug.
// - Armed block stays armed when host enters background debug.
// - Debug disabled: software interrupt only; debug active: nothing.
// - Bank select field chooses visible comparator bank and 0x27 register.
// - While armed only arm, trigger and bank select bits are writable.
// - Breakpoint routed to debug but debug not enabled becomes software interrupt.
// - Setting arm enters first state; arm clears when session completes.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_bus_trace_debugger_defs.vh"

module cpu_bus_trace_debugger (
  input  wire        clk,
  input  wire        rstn,
  input  wire [7:0]  regAddr,
  input  wire        regWr,
  input  wire        regRd,
  input  wire        regWord,
  input  wire [7:0]  regWdata,
  output reg  [15:0] regRdata,
  input  wire        busValid,
  input  wire [17:0] busAddr,
  input  wire [15:0] busData,
  input  wire        busWrite,
  input  wire        busByte,
  input  wire        busFree,
  input  wire        busOpFetch,
  input  wire        execValid,
  input  wire [17:0] execPc,
  input  wire        instrBoundary,
  input  wire        cofValid,
  input  wire [17:0] cofSrc,
  input  wire        secure,
  input  wire        bdmEnable,
  input  wire        bdmActive,
  input  wire        bdmAccess,
  output reg         bkptBdm,
  output reg         bkptSwi
);

  localparam [2:0] IDLE_STATE   = `ST_IDLE;
  localparam [2:0] FIRST_STATE  = `ST_FIRST;
  localparam [2:0] SECOND_STATE = `ST_SECOND;
  localparam [2:0] THIRD_STATE  = `ST_THIRD;
  localparam [2:0] FINAL_STATE  = `ST_FINAL;

  reg        arm;
  reg        bdmSel;
  reg        brkEn;
  reg [1:0]  comparator_bank_select;
  reg        trace_source_enable;
  reg [1:0]  trace_mode_select;
  reg        trigger_alignment_select;
  reg [1:0]  comparator_pairing_mode;
  reg [7:0]  ctl [0:2];
  reg [17:0] cmpAddr [0:2];
  reg [15:0] cmpData;
  reg [15:0] cmpMask;
  reg [3:0]  scr [0:2];
  reg [2:0]  matchFlags;
  reg [2:0]  seqState;
  reg        tracing;
  reg [2:0]  forcePend;
  reg [2:0]  tagPend;
  reg [17:0] tagPc [0:2];
  reg [19:0] mem [0:15];
  reg [3:0]  wrPtr;
  reg [4:0]  lineCnt;
  reg [3:0]  rdOff;
  reg        rdHalf;
  reg [17:0] lastSrc;
  reg        haveLast;

  // Direction qualifier shared by all three comparators; size qualifier by the first two only
  function cmpOk;
    input [7:0] c;
    input       addrOk;
    input       wr;
    input       byt;
    begin
      cmpOk = c[`CC_COMPARATOR_ON] && addrOk &&
              (!c[`CC_RWE] || (c[`CC_RW] == !wr)) &&
              (!c[`CC_SZE] || (c[`CC_SZ] == byt));
    end
  endfunction

  // Debug activity only pauses monitoring; arm is left as it is
  wire monOn = arm & ~bdmActive & ~bdmAccess;
  wire traceOn = trace_source_enable & ~secure;
  wire full = (lineCnt == `TRACE_DEPTH);
  wire rangeMode = (comparator_pairing_mode != `PAIR_SIMPLE);
  wire inRange = (busAddr >= cmpAddr[0]) && (busAddr <= cmpAddr[1]);
  wire rangeOk = (comparator_pairing_mode == `PAIR_INSIDE) ? inRange : ~inRange;
  wire dataOk = ((((busData ^ cmpData) & cmpMask) == 16'h0000)
                 ^ ctl[0][`CC_NDB]);
  wire busSeen = busValid & monOn;
  wire trigReq = regWr & (regAddr == `OFS_CONTROL_ONE) & regWdata[`C1_IMMEDIATE_TRIGGER_REQUEST];

  reg [2:0] busHit;
  reg [2:0] tagHit;
  reg [2:0] eff;
  reg [2:0] brkMask;
  integer   i;
  // Own loop index per process keeps each variable single-driven
  integer   j;

  always @* begin
    busHit[0] = busSeen & (rangeMode | dataOk) &
                cmpOk(ctl[0], rangeMode ? rangeOk : (busAddr == cmpAddr[0]),
                      busWrite, busByte);
    // Second comparator serves as upper bound in range modes
    busHit[1] = busSeen & ~rangeMode &
                cmpOk(ctl[1], busAddr == cmpAddr[1], busWrite, busByte);
    busHit[2] = busSeen &
                cmpOk(ctl[2], busAddr == cmpAddr[2], busWrite, busByte);
    for (j = 0; j < 3; j = j + 1) begin
      tagHit[j] = execValid & monOn & tagPend[j] & (execPc == tagPc[j]);
      eff[j] = ctl[j][`CC_TAG] ? tagHit[j]
                               : (instrBoundary & forcePend[j]);
      brkMask[j] = ctl[j][`CC_BRK];
    end
  end

  reg [3:0] scrCur;
  reg [2:0] next_seqState;

  always @* begin
    case (seqState)
      FIRST_STATE:  scrCur = scr[0];
      SECOND_STATE: scrCur = scr[1];
      THIRD_STATE:  scrCur = scr[2];
      default:    scrCur = 4'h0;
    endcase
    next_seqState = seqState;
    case (seqState)
      FIRST_STATE, SECOND_STATE, THIRD_STATE: begin
        if (|(eff & brkMask) || (scrCur[3] && |eff))
          next_seqState = FINAL_STATE;
        else if (|(eff & scrCur[2:0]))
          next_seqState = seqState + 3'h1;
      end
      default: next_seqState = seqState;
    endcase
    if (trigReq && arm)
      next_seqState = FINAL_STATE;
  end

  wire finalEnter = arm && (seqState != FINAL_STATE) &&
                    (next_seqState == FINAL_STATE);
  wire beginStart = finalEnter & traceOn & trigger_alignment_select & ~tracing;
  // Trigger while begin-aligned capture runs changes nothing
  wire sessionEnd = (finalEnter & ~(traceOn & trigger_alignment_select)) |
                    (tracing & trigger_alignment_select & full);

  reg        we1;
  reg        we2;
  reg [19:0] line1;
  reg [19:0] line2;
  wire       capture = tracing & monOn & ~(trigger_alignment_select & full);

  always @* begin
    we1 = 1'b0;
    we2 = 1'b0;
    line1 = {`LINE_ADDR, cofSrc};
    line2 = {`LINE_DATA, 2'b00, busData};
    case (trace_mode_select)
      `TM_NORMAL: we1 = capture & cofValid;
      `TM_LOOP:
        we1 = capture & cofValid &
              ~(haveLast & (cofSrc == lastSrc));
      `TM_DETAIL: begin
        we1 = capture & busValid & ~busFree & ~busOpFetch;
        we2 = we1;
        line1 = {`LINE_ADDR, busAddr};
      end
      `TM_PURE_PC: begin
        we1 = capture & execValid;
        line1 = {`LINE_ADDR, execPc};
      end
      default: we1 = 1'b0;
    endcase
  end

  // No reset on the array; contents only count once lineCnt says so
  always @(posedge clk) begin
    if (we1)
      mem[wrPtr] <= line1;
    if (we2)
      mem[wrPtr + 4'h1] <= line2;
  end

  wire [4:0] addCnt = {4'h0, we1} + {4'h0, we2};
  wire [4:0] sumCnt = lineCnt + addCnt;
  wire [3:0] rdIdx = (full ? wrPtr : 4'h0) + rdOff;
  wire [19:0] rdLine = mem[rdIdx];
  wire [15:0] curWord = rdHalf ? rdLine[15:0] : {12'h000, rdLine[19:16]};
  wire [1:0] sel = comparator_bank_select;
  wire bankOn = (comparator_bank_select != `BANK_NONE);
  wire selA = (comparator_bank_select == 2'h0);
  wire wrOpen = regWr & ~arm;
  wire bankWr = wrOpen & bankOn;

  reg [7:0] rdByte;

  always @* begin
    rdByte = `RST_BYTE;
    case (regAddr)
      `OFS_CONTROL_ONE:
        rdByte = {arm, 2'b00, bdmSel, brkEn, 1'b0, comparator_bank_select};
      `OFS_STATE_FLAGS:   rdByte = {full, 4'h0, seqState};
      `OFS_TRACE_CONTROL:
        rdByte = {1'b0, trace_source_enable, 2'b00, trace_mode_select, 1'b0, trigger_alignment_select};
      `OFS_CONTROL_TWO:   rdByte = {6'h00, comparator_pairing_mode};
      `OFS_TRACE_HIGH:    rdByte = curWord[15:8];
      `OFS_TRACE_LOW:     rdByte = curWord[7:0];
      `OFS_ENTRY_COUNT:   rdByte = {full, 2'b00, lineCnt};
      `OFS_SEQ_CONTROL:
        rdByte = bankOn ? {4'h0, scr[sel]} : {5'h00, matchFlags};
      `OFS_CMP_CONTROL:   rdByte = bankOn ? ctl[sel] : 8'h00;
      `OFS_ADDR_UPPER:
        rdByte = bankOn ? {6'h00, cmpAddr[sel][17:16]} : 8'h00;
      `OFS_ADDR_MIDDLE:   rdByte = bankOn ? cmpAddr[sel][15:8] : 8'h00;
      `OFS_ADDR_LOWER:    rdByte = bankOn ? cmpAddr[sel][7:0] : 8'h00;
      `OFS_DATA_HIGH:     rdByte = selA ? cmpData[15:8] : 8'h00;
      `OFS_DATA_LOW:      rdByte = selA ? cmpData[7:0] : 8'h00;
      `OFS_MASK_HIGH:     rdByte = selA ? cmpMask[15:8] : 8'h00;
      `OFS_MASK_LOW:      rdByte = selA ? cmpMask[7:0] : 8'h00;
      default:            rdByte = `RST_BYTE;
    endcase
  end

  wire wordRead = regRd & regWord & (regAddr == `OFS_TRACE_HIGH);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arm <= 1'b0;
      bdmSel <= 1'b0;
      brkEn <= 1'b0;
      comparator_bank_select <= 2'h0;
      trace_source_enable <= 1'b0;
      trace_mode_select <= `TM_NORMAL;
      trigger_alignment_select <= 1'b0;
      comparator_pairing_mode <= `PAIR_SIMPLE;
      for (i = 0; i < 3; i = i + 1) begin
        ctl[i] <= `RST_BYTE;
        cmpAddr[i] <= 18'h00000;
        scr[i] <= 4'h0;
        tagPc[i] <= 18'h00000;
      end
      cmpData <= 16'h0000;
      cmpMask <= 16'h0000;
      matchFlags <= 3'h0;
      seqState <= IDLE_STATE;
      tracing <= 1'b0;
      forcePend <= 3'h0;
      tagPend <= 3'h0;
      wrPtr <= 4'h0;
      lineCnt <= 5'h00;
      rdOff <= 4'h0;
      rdHalf <= 1'b0;
      lastSrc <= 18'h00000;
      haveLast <= 1'b0;
      regRdata <= 16'h0000;
      bkptBdm <= 1'b0;
      bkptSwi <= 1'b0;
    end else begin
      bkptBdm <= 1'b0;
      bkptSwi <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
        // A new hit in the consuming cycle keeps the flag set
        forcePend[i] <= arm & ((busHit[i] & ~ctl[i][`CC_TAG]) |
                               (forcePend[i] & ~instrBoundary));
        if (!arm)
          tagPend[i] <= 1'b0;
        else if (busHit[i] & ctl[i][`CC_TAG] & busOpFetch) begin
          tagPend[i] <= 1'b1;
          tagPc[i] <= busAddr;
        end else if (tagHit[i])
          tagPend[i] <= 1'b0;
      end
      matchFlags <= matchFlags | eff;
      seqState <= next_seqState;
      if (we1) begin
        wrPtr <= wrPtr + (we2 ? 4'h2 : 4'h1);
        lineCnt <= (sumCnt > `TRACE_DEPTH) ? `TRACE_DEPTH : sumCnt;
        lastSrc <= cofSrc;
        haveLast <= 1'b1;
      end
      if (beginStart)
        tracing <= 1'b1;
      if (sessionEnd) begin
        arm <= 1'b0;
        tracing <= 1'b0;
        seqState <= IDLE_STATE;
        rdOff <= 4'h0;
        rdHalf <= 1'b0;
        if (brkEn && !(bdmEnable && bdmActive)) begin
          bkptBdm <= bdmSel & bdmEnable;
          bkptSwi <= ~(bdmSel & bdmEnable);
        end
      end
      if (regRd) begin
        regRdata <= wordRead ? curWord : {8'h00, rdByte};
        if (wordRead) begin
          rdHalf <= ~rdHalf;
          if (rdHalf)
            rdOff <= rdOff + 4'h1;
        end
      end
      if (regWr && regAddr == `OFS_CONTROL_ONE) begin
        comparator_bank_select <= regWdata[1:0];
        if (!arm) begin
          bdmSel <= regWdata[`C1_BDM];
          brkEn <= regWdata[`C1_BRK_EN];
        end
        if (regWdata[`C1_ARM] && !arm) begin
          arm <= 1'b1;
          seqState <= FIRST_STATE;
          tracing <= traceOn & ~trigger_alignment_select;
          wrPtr <= 4'h0;
          lineCnt <= 5'h00;
          rdOff <= 4'h0;
          rdHalf <= 1'b0;
          matchFlags <= 3'h0;
          haveLast <= 1'b0;
        end else if (!regWdata[`C1_ARM] && arm) begin
          arm <= 1'b0;
          seqState <= IDLE_STATE;
          tracing <= 1'b0;
        end
      end
      if (wrOpen) begin
        case (regAddr)
          `OFS_TRACE_CONTROL: begin
            trace_source_enable <= regWdata[`TC_TRACE_SOURCE_ENABLE];
            trace_mode_select <= regWdata[3:2];
            trigger_alignment_select <= regWdata[`TC_TRIGGER_ALIGNMENT_SELECT];
          end
          `OFS_CONTROL_TWO: comparator_pairing_mode <= regWdata[1:0];
          `OFS_DATA_HIGH: if (selA) cmpData[15:8] <= regWdata;
          `OFS_DATA_LOW:  if (selA) cmpData[7:0] <= regWdata;
          `OFS_MASK_HIGH: if (selA) cmpMask[15:8] <= regWdata;
          `OFS_MASK_LOW:  if (selA) cmpMask[7:0] <= regWdata;
          default: ;
        endcase
      end
      if (bankWr) begin
        case (regAddr)
          `OFS_SEQ_CONTROL: scr[sel] <= regWdata[3:0];
          `OFS_CMP_CONTROL:
            ctl[sel] <= regWdata & (selA ? `CTL_MASK_A :
                        (sel == 2'h1) ? `CTL_MASK_B : `CTL_MASK_C);
          `OFS_ADDR_UPPER:  cmpAddr[sel][17:16] <= regWdata[1:0];
          `OFS_ADDR_MIDDLE: cmpAddr[sel][15:8] <= regWdata;
          `OFS_ADDR_LOWER:  cmpAddr[sel][7:0] <= regWdata;
          default: ;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// File: testbench/cpu_bus_trace_debugger_monitor.sv
// Concurrent checks on register reads and breakpoint pulses of the debugger
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_trace_debugger_monitor (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [7:0]  regAddr,
  input wire logic        regRd,
  input wire logic        regWord,
  input wire logic [15:0] regRdata,
  input wire logic        bdmEnable,
  input wire logic        bdmActive,
  input wire logic        bkptBdm,
  input wire logic        bkptSwi
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_quiet; !$past(rstn) |-> !bkptBdm && !bkptSwi; endproperty
  a_quiet: assert property (p_quiet) else $error("break at reset release");
  property p_oneWay; !(bkptBdm && bkptSwi); endproperty
  a_oneWay: assert property (p_oneWay) else $error("both break kinds");
  property p_pulse; bkptBdm || bkptSwi |=> !bkptBdm && !bkptSwi; endproperty
  a_pulse: assert property (p_pulse) else $error("break held too long");
  property p_bdmOk; bkptBdm |-> $past(bdmEnable); endproperty
  a_bdmOk: assert property (p_bdmOk) else $error("debug break while disabled");
  property p_silent; (bdmEnable && bdmActive) [*2] |-> !bkptBdm && !bkptSwi; endproperty
  a_silent: assert property (p_silent) else $error("break in active debug");
  property p_unmapped; regRd && (regAddr < 8'h20 || regAddr > 8'h2F) |=> regRdata == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold; !regRd |=> $stable(regRdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_byte; regRd && !regWord |=> regRdata[15:8] == 8'h00; endproperty
  a_byte: assert property (p_byte) else $error("byte read upper not zero");
  property p_trigZero; regRd && regAddr == 8'h20 |=> regRdata[6:5] == 2'b00; endproperty
  a_trigZero: assert property (p_trigZero) else $error("trigger bit read as one");
  c_bdm: cover property (bkptBdm);
  c_swi: cover property (bkptSwi);
  c_word: cover property (regRd && regWord);
endmodule
bind cpu_bus_trace_debugger cpu_bus_trace_debugger_monitor u_cpu_bus_trace_debugger_monitor (
  .clk, .rstn, .regAddr, .regRd, .regWord, .regRdata, .bdmEnable, .bdmActive, .bkptBdm, .bkptSwi
);
`default_nettype wire

// File: testbench/cpu_bus_model.sv
// Behavioural CPU side: bus cycles, boundaries, execution and flow changes
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
  input  wire logic        clk,
  output var  logic        busValid = 1'b0,
  output var  logic [17:0] busAddr = 18'h00000,
  output var  logic [15:0] busData = 16'h0000,
  output var  logic        busWrite = 1'b0,
  output var  logic        busByte = 1'b0,
  output var  logic        busFree = 1'b0,
  output var  logic        busOpFetch = 1'b0,
  output var  logic        execValid = 1'b0,
  output var  logic [17:0] execPc = 18'h00000,
  output var  logic        instrBoundary = 1'b0,
  output var  logic        cofValid = 1'b0,
  output var  logic [17:0] cofSrc = 18'h00000
);
  // Released lines show the inverse, so a stale value never looks valid
  task automatic cyc(input logic [17:0] a, input logic [15:0] d, input logic w);
    @(posedge clk);
    busValid <= 1'b1;
    busAddr <= a;
    busData <= d;
    busWrite <= w;
    @(posedge clk);
    busValid <= 1'b0;
    busAddr <= ~a;
    busData <= ~d;
    busWrite <= ~w;
    instrBoundary <= 1'b1;
    @(posedge clk);
    instrBoundary <= 1'b0;
  endtask
  task automatic flow(input logic [17:0] s);
    @(posedge clk);
    cofValid <= 1'b1;
    execValid <= 1'b1;
    cofSrc <= s;
    execPc <= s;
    @(posedge clk);
    cofValid <= 1'b0;
    execValid <= 1'b0;
    cofSrc <= ~s;
    execPc <= ~s;
  endtask
  // Opcode fetch, then the same opcode reaches execution three cycles later
  task automatic fetchExec(input logic [17:0] a);
    @(posedge clk);
    busValid <= 1'b1;
    busOpFetch <= 1'b1;
    busAddr <= a;
    @(posedge clk);
    busValid <= 1'b0;
    busOpFetch <= 1'b0;
    busAddr <= ~a;
    repeat (2) @(posedge clk);
    execValid <= 1'b1;
    execPc <= a;
    @(posedge clk);
    execValid <= 1'b0;
    execPc <= ~a;
  endtask
endmodule
`default_nettype wire

// File: testbench/cpu_bus_trace_debugger_tb.sv
// Self-checking bench of the bus trace debugger
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_trace_debugger_tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWdata = 8'h00;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        regWord = 1'b0;
  logic        secure = 1'b0;
  logic        bdmEnable = 1'b0;
  logic        bdmActive = 1'b0;
  logic        bdmAccess = 1'b0;
  wire  [15:0] regRdata, busData;
  wire  [17:0] busAddr, execPc, cofSrc;
  wire         bkptBdm, bkptSwi, busValid, busWrite, busByte, busFree;
  wire         busOpFetch, execValid, instrBoundary, cofValid;
  int          numErrors = 0;
  int          nChecks = 0;
  always #5 clk = ~clk;
  cpu_bus_trace_debugger u_cpu_bus_trace_debugger (.clk, .rstn, .regAddr, .regWr, .regRd, .regWord,
    .regWdata, .regRdata, .busValid, .busAddr, .busData, .busWrite, .busByte, .busFree, .busOpFetch,
    .execValid, .execPc, .instrBoundary, .cofValid, .cofSrc, .secure, .bdmEnable, .bdmActive,
    .bdmAccess, .bkptBdm, .bkptSwi);
  cpu_bus_model u_cpu_bus_model (.clk, .busValid, .busAddr, .busData, .busWrite, .busByte, .busFree,
    .busOpFetch, .execValid, .execPc, .instrBoundary, .cofValid, .cofSrc);
  task automatic report_and_stop;
    $display("checks %0d errors %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic w, input logic [15:0] exp);
    @(posedge clk);
    regAddr <= a;
    regWord <= w;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    #1 chk(regRdata, exp);
  endtask
  // Pulses may land on the write edge itself, so sample before waiting
  task automatic waitBk(input logic eb, input logic es);
    logic gb;
    logic gs;
    gb = 1'b0;
    gs = 1'b0;
    repeat (8) begin
      #1 gb = gb | bkptBdm;
      gs = gs | bkptSwi;
      @(posedge clk);
    end
    chk({14'h0000, gb, gs}, {14'h0000, eb, es});
  endtask
  task automatic doReset;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task automatic setComp(input logic [1:0] b, input logic [7:0] c, input logic [17:0] a);
    wr(8'h20, {6'h00, b});
    wr(8'h28, c);
    wr(8'h29, {6'h00, a[17:16]});
    wr(8'h2A, a[15:8]);
    wr(8'h2B, a[7:0]);
  endtask
  task automatic t_immediate_trigger_request;
    for (int i = 0; i < 3; i++) begin
      doReset;
      bdmEnable <= (i == 1);
      wr(8'h20, i == 0 ? 8'h88 : 8'h98);
      rdChk(8'h21, 1'b0, 16'h0001);
      wr(8'h20, i == 0 ? 8'hC8 : 8'hD8);
      waitBk(i == 1, i != 1);
      rdChk(8'h20, 1'b0, i == 0 ? 16'h0008 : 16'h0018);
    end
    bdmEnable <= 1'b0;
  endtask
  task automatic t_bdm;
    doReset;
    bdmEnable <= 1'b1;
    wr(8'h20, 8'h98);
    bdmActive <= 1'b1;
    rdChk(8'h20, 1'b0, 16'h0098);
    wr(8'h20, 8'hD8);
    waitBk(1'b0, 1'b0);
    bdmActive <= 1'b0;
    bdmEnable <= 1'b0;
  endtask
  task automatic t_lock;
    doReset;
    wr(8'h20, 8'h80);
    wr(8'h20, 8'h99);
    wr(8'h22, 8'h40);
    rdChk(8'h20, 1'b0, 16'h0081);
    rdChk(8'h22, 1'b0, 16'h0000);
  endtask
  task automatic t_match;
    doReset;
    setComp(2'h0, 8'h1D, 18'h01234);
    wr(8'h2C, 8'hBE);
    wr(8'h2D, 8'hEF);
    wr(8'h2E, 8'hFF);
    wr(8'h2F, 8'hFF);
    wr(8'h20, 8'h88);
    for (int i = 0; i < 5; i++) begin
      bdmAccess <= (i == 3);
      u_cpu_bus_model.cyc(i == 2 ? 18'h01235 : 18'h01234, i == 1 ? 16'h1111 : 16'hBEEF, i == 0);
      waitBk(1'b0, i == 4);
    end
  endtask
  task automatic t_range;
    logic [1:0]  md [6] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
    logic [17:0] ad [6] = '{18'h00100, 18'h00200, 18'h00201, 18'h000FF, 18'h00100, 18'h00201};
    logic [5:0]  ex = 6'b101011;
    doReset;
    setComp(2'h1, 8'h01, 18'h00200);
    rdChk(8'h28, 1'b0, 16'h0001);
    setComp(2'h0, 8'h11, 18'h00100);
    rdChk(8'h28, 1'b0, 16'h0011);
    for (int i = 0; i < 6; i++) begin
      wr(8'h23, {6'h00, md[i]});
      wr(8'h20, 8'h88);
      u_cpu_bus_model.cyc(ad[i], 16'h0000, 1'b0);
      waitBk(1'b0, ex[i]);
      wr(8'h20, 8'h08);
    end
  endtask
  task automatic t_trace(input logic [1:0] m, input logic sec, input logic [17:0] s2, input logic [7:0] n);
    doReset;
    secure <= sec;
    wr(8'h22, {4'h4, m, 2'h0});
    wr(8'h20, 8'h80);
    u_cpu_bus_model.flow(18'h00ABC);
    u_cpu_bus_model.flow(s2);
    u_cpu_bus_model.cyc(18'h00ABC, 16'h5A5A, 1'b0);
    wr(8'h20, 8'hC0);
    rdChk(8'h26, 1'b0, {8'h00, n});
    if (n != 8'h00) begin
      rdChk(8'h24, 1'b1, 16'h0000);
      rdChk(8'h24, 1'b1, 16'h0ABC);
    end
    secure <= 1'b0;
  endtask
  // Third comparator steps state 1 to 2, tagged second comparator triggers
  // begin-aligned capture, which ends the session after sixteen lines
  task automatic t_seq;
    doReset;
    setComp(2'h1, 8'h31, 18'h00400);
    setComp(2'h2, 8'h01, 18'h00300);
    wr(8'h20, 8'h08);
    wr(8'h27, 8'h04);
    wr(8'h22, 8'h41);
    wr(8'h20, 8'h88);
    u_cpu_bus_model.flow(18'h00111);
    u_cpu_bus_model.cyc(18'h00300, 16'hFFFF, 1'b1);
    rdChk(8'h21, 1'b0, 16'h0002);
    u_cpu_bus_model.fetchExec(18'h00400);
    waitBk(1'b0, 1'b0);
    rdChk(8'h21, 1'b0, 16'h0004);
    repeat (16) u_cpu_bus_model.flow(18'h00222);
    waitBk(1'b0, 1'b1);
    rdChk(8'h26, 1'b0, 16'h0090);
    rdChk(8'h24, 1'b1, 16'h0000);
    rdChk(8'h24, 1'b1, 16'h0222);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rdChk(8'h20, 1'b0, 16'h0000);
    rdChk(8'h21, 1'b0, 16'h0000);
    rdChk(8'h30, 1'b0, 16'h0000);
    t_immediate_trigger_request;
    t_bdm;
    t_lock;
    t_match;
    t_range;
    t_trace(2'h0, 1'b0, 18'h00DEF, 8'h02);
    t_trace(2'h1, 1'b0, 18'h00ABC, 8'h01);
    t_trace(2'h2, 1'b0, 18'h00DEF, 8'h02);
    t_trace(2'h3, 1'b0, 18'h00DEF, 8'h02);
    t_trace(2'h0, 1'b1, 18'h00DEF, 8'h00);
    t_seq;
    report_and_stop;
  end
  // Run needs about 550 cycles; over fifty times that means a hang
  initial begin
    #300000;
    numErrors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
